// File: rtl/efn_ctrl.sv
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
// AXI4-Lite controller: issues device register accesses, reports the request line.
module efn_ctrl
    import efn_pkg::*;
(
    input  wire logic        aclk,     // Clock.
    input  wire logic        aresetn,  // Synchronous reset, active low.
    efn_if.ctl               bus,      // Port to the device.
    input  wire logic [5:0]  awaddr,   // Write address.
    input  wire logic        awvalid,  // Write address valid.
    output logic             awready,  // Write address ready.
    input  wire logic [31:0] wdata,    // Write data.
    input  wire logic [3:0]  wstrb,    // Write strobes.
    input  wire logic        wvalid,   // Write data valid.
    output logic             wready,   // Write data ready.
    output logic [1:0]       bresp,    // Write response.
    output logic             bvalid,   // Write response valid.
    input  wire logic        bready,   // Write response ready.
    input  wire logic [5:0]  araddr,   // Read address.
    input  wire logic        arvalid,  // Read address valid.
    output logic             arready,  // Read address ready.
    output logic [31:0]      rdata,    // Read data.
    output logic [1:0]       rresp,    // Read response.
    output logic             rvalid,   // Read data valid.
    input  wire logic        rready,   // Read data ready.
    output logic             irq       // Controller interrupt, active high.
);

    typedef enum logic [1:0] {IDLE = 2'b00, ISSUE = 2'b01, WAITR = 2'b11} op_t;

    typedef struct packed {
        op_t              op;
        logic             is_rd;
        logic [3:0]       addr;
        logic [7:0]       wd;
        logic [7:0]       rd;
        logic             aw_h;
        logic             w_h;
        logic [5:0]       awa;
        logic [31:0]      wdv;
        logic             bv;
        logic [1:0]       br;
        logic             rv;
        logic [31:0]      rdt;
        logic [1:0]       rr;
        logic [CIRQ_W-1:0] st;
        logic [CIRQ_W-1:0] msk;
        logic [31:0]      tload;
        logic [31:0]      tcnt;
        logic             irq_n_m;
        logic             irq_n_s;
    } state_t;

    state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.irq_n_m = bus.irq_n;
        s_d.irq_n_s = s_q.irq_n_m;
        if (!s_q.irq_n_s) begin
            s_d.st[CI_DEV] = 1'b1;
        end
        // Software timeout used to rearm the receive FIFO.
        if (s_q.tcnt != 32'h0) begin
            s_d.tcnt = s_q.tcnt - 32'h1;
            if (s_q.tcnt == 32'h1) begin
                s_d.st[CI_TOUT] = 1'b1;
            end
        end
        case (s_q.op)
            ISSUE: begin
                s_d.op = s_q.is_rd ? WAITR : IDLE;
            end
            WAITR: begin
                s_d.rd = bus.reg_rdata;
                s_d.op = IDLE;
                s_d.st[CI_DONE] = 1'b1;
            end
            default: begin
            end
        endcase
        if (awvalid && awready) begin
            s_d.aw_h = 1'b1;
            s_d.awa  = awaddr;
        end
        if (wvalid && wready) begin
            s_d.w_h = 1'b1;
            s_d.wdv = wdata;
        end
        if (s_q.aw_h && s_q.w_h && !s_q.bv) begin
            s_d.aw_h = 1'b0;
            s_d.w_h  = 1'b0;
            s_d.bv   = 1'b1;
            s_d.br   = RESP_OKAY;
            if (s_q.awa == C_CMD) begin
                if (s_q.op == IDLE) begin
                    s_d.op    = ISSUE;
                    s_d.addr  = s_q.wdv[3:0];
                    s_d.is_rd = s_q.wdv[8];
                end
            end else if (s_q.awa == C_WDATA) begin
                s_d.wd = s_q.wdv[7:0];
            end else if (s_q.awa == C_IMASK) begin
                s_d.msk = s_q.wdv[CIRQ_W-1:0];
            end else if (s_q.awa == C_TIMER) begin
                s_d.tload = s_q.wdv;
                s_d.tcnt  = s_q.wdv;
            end else if (s_q.awa != C_RDATA && s_q.awa != C_STAT) begin
                s_d.br = RESP_SLVERR;
            end
        end
        if (s_q.bv && bready) begin
            s_d.bv = 1'b0;
        end
        if (arvalid && arready) begin
            s_d.rv  = 1'b1;
            s_d.rr  = RESP_OKAY;
            s_d.rdt = 32'h0;
            if (araddr == C_CMD) begin
                s_d.rdt = {23'h0, s_q.is_rd, 4'h0, s_q.addr};
            end else if (araddr == C_WDATA) begin
                s_d.rdt = {24'h0, s_q.wd};
            end else if (araddr == C_RDATA) begin
                s_d.rdt = {24'h0, s_q.rd};
            end else if (araddr == C_STAT) begin
                s_d.rdt = {27'h0, s_q.op != IDLE, ~s_q.irq_n_s, s_q.st};
                s_d.st  = s_d.st & ~s_q.st;
            end else if (araddr == C_IMASK) begin
                s_d.rdt = {29'h0, s_q.msk};
            end else if (araddr == C_TIMER) begin
                s_d.rdt = s_q.tcnt;
            end else begin
                s_d.rr = RESP_SLVERR;
            end
        end
        if (s_q.rv && rready) begin
            s_d.rv = 1'b0;
        end
        if (!aresetn) begin
            s_d = '0;
            s_d.op = IDLE;
            s_d.irq_n_m = 1'b1;
            s_d.irq_n_s = 1'b1;
            s_d.tload = TOUT_RESET;
        end
    end

    always_ff @(posedge aclk) begin
        s_q <= s_d;
    end

    assign awready       = !s_q.aw_h && aresetn;
    assign wready        = !s_q.w_h && aresetn;
    assign arready       = !s_q.rv && aresetn;
    assign bvalid        = s_q.bv;
    assign bresp         = s_q.br;
    assign rvalid        = s_q.rv;
    assign rdata         = s_q.rdt;
    assign rresp         = s_q.rr;
    assign bus.reg_we    = (s_q.op == ISSUE) && !s_q.is_rd;
    assign bus.reg_re    = (s_q.op == ISSUE) && s_q.is_rd;
    assign bus.reg_addr  = s_q.addr;
    assign bus.reg_wdata = s_q.wd;
    assign irq           = |(s_q.st & s_q.msk);

endmodule

// File: rtl/efn_pkg.sv
package efn_pkg;

    // Interrupt register bit positions, one per source.
    localparam int IRQ_TX0     = 0;
    localparam int IRQ_EP0RX   = 1;
    localparam int IRQ_EP1TX   = 2;
    localparam int IRQ_RST     = 3;
    localparam int IRQ_SUS     = 4;
    localparam int IRQ_W       = 5;

    // Device register indices on the local register port.
    localparam logic [3:0] DEV_INT      = 4'h0;
    localparam logic [3:0] DEV_MASK     = 4'h1;
    localparam logic [3:0] DEV_TX0_CF   = 4'h2;
    localparam logic [3:0] DEV_TX0_ST   = 4'h3;
    localparam logic [3:0] DEV_EP0RX_CF = 4'h4;
    localparam logic [3:0] DEV_EP1_CF   = 4'h5;
    localparam logic [3:0] DEV_STATUS   = 4'h6;

    // EP0 transmit control bits.
    localparam int TXC_ENABLE  = 0;
    localparam int TXC_CLEAR   = 1;
    // EP0 transmit status bits.
    localparam int TXS_ACK     = 0;
    localparam int TXS_UNDER   = 1;
    localparam int TXS_OVER    = 2;
    localparam int TXS_STAGE   = 3;
    // EP0 receive control bits.
    localparam int RXC_ENABLE  = 0;
    localparam int RXC_FIFOEN  = 1;
    // Device status read bits.
    localparam int DST_CONN    = 0;
    localparam int DST_SUSP    = 1;
    localparam int DST_EP1RUN  = 2;

    localparam logic [7:0] INT_RESET   = 8'h00;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    localparam logic [7:0] RST_CLEAR   = 8'h08;
    localparam logic [7:0] SUS_CLEAR   = 8'h10;

    // Controller AXI register byte offsets.
    localparam logic [5:0] C_CMD    = 6'h00;
    localparam logic [5:0] C_WDATA  = 6'h04;
    localparam logic [5:0] C_RDATA  = 6'h08;
    localparam logic [5:0] C_STAT   = 6'h0c;
    localparam logic [5:0] C_IMASK  = 6'h10;
    localparam logic [5:0] C_TIMER  = 6'h14;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    localparam int CIRQ_W = 3;
    localparam int CI_DONE = 0;
    localparam int CI_DEV  = 1;
    localparam int CI_TOUT = 2;

    localparam logic [31:0] TOUT_RESET = 32'h0000_0000;

endpackage

// File: rtl/efn_if.sv
`timescale 1ns/10ps
interface efn_if;
    logic       irq_n;      // Active-low interrupt request from the device.
    logic       reg_we;     // Register write strobe.
    logic       reg_re;     // Register read strobe.
    logic [3:0] reg_addr;   // Register index.
    logic [7:0] reg_wdata;  // Write data.
    logic [7:0] reg_rdata;  // Read data, valid the cycle after reg_re.

    modport dev (output irq_n, reg_rdata, input reg_we, reg_re, reg_addr, reg_wdata);
    modport ctl (input irq_n, reg_rdata, output reg_we, reg_re, reg_addr, reg_wdata);
endinterface

// File: rtl/efn_device.sv
`timescale 1ns/10ps
// Summary of operation
// - Power-up clears interrupts, request line high
// - Connected only when both EP0 enables set
// - Mask bit 1 lets source assert request
// - Five interrupt sources, one bit each
// - Endpoint 1 runs only when enabled
// - Controller reads interrupt register on request
// - Host reset/setup clears all, then sets new
// - Controller timeout checks status stage, rearms
// - Receive FIFO enable rearms receive FIFO
// - Transmit ACK sets bit and interrupt
// - Controller loads FIFO and count before IN
// - Receive FIFO enable lets OUT status ack
// - Underrun/overrun flag interrupt; clear bit clears
// - Function reset clears all but masks, EP0 enables
// - Writing 08h clears function reset interrupt
// - Writing 10h clears suspend, enters suspend
module efn_device
    import efn_pkg::*;
(
    input  wire logic aclk,          // Device clock.
    input  wire logic aresetn,       // Synchronous reset, active low.
    efn_if.dev        bus,           // Register port to the controller.
    input  wire logic usb_reset,     // Host function reset pulse.
    input  wire logic usb_setup,     // Host new setup transaction pulse.
    input  wire logic usb_suspend,   // Suspend detected pulse.
    input  wire logic ep0_tx_ack,    // EP0 IN transaction acknowledged pulse.
    input  wire logic ep0_tx_stage,  // The acknowledged IN was a status stage.
    input  wire logic ep0_tx_under,  // EP0 transmit FIFO under-run pulse.
    input  wire logic ep0_tx_over,   // EP0 transmit FIFO over-run pulse.
    input  wire logic ep0_rx_done,   // EP0 OUT packet received pulse.
    input  wire logic ep1_tx_ack,    // EP1 IN transaction acknowledged pulse.
    output logic      connected,     // Function logically attached to hub.
    output logic      rx_armed,      // Receive FIFO accepts the next packet.
    output logic      ep1_active,    // Endpoint 1 operating.
    output logic      suspended      // Low-power suspend, clocks not gated.
);

    typedef struct packed {
        logic [IRQ_W-1:0] intr;
        logic [IRQ_W-1:0] mask;
        logic             tx_en;
        logic             rx_en;
        logic             ep1_en;
        logic             rx_fifo_en;
        logic             ack;
        logic             under;
        logic             over;
        logic             stage;
        logic             susp;
        logic [7:0]       rdata;
    } state_t;

    state_t s_q, s_d;

    logic [7:0]       rd;
    logic [IRQ_W-1:0] pend;

    ////////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; the selected value is registered on a read strobe.
    always_comb begin
        rd = 8'h00;
        if (bus.reg_addr == DEV_INT) begin
            rd = 8'(s_q.intr);
        end else if (bus.reg_addr == DEV_MASK) begin
            rd = 8'(s_q.mask);
        end else if (bus.reg_addr == DEV_TX0_CF) begin
            rd[TXC_ENABLE] = s_q.tx_en;
        end else if (bus.reg_addr == DEV_TX0_ST) begin
            rd[TXS_ACK]   = s_q.ack;
            rd[TXS_UNDER] = s_q.under;
            rd[TXS_OVER]  = s_q.over;
            rd[TXS_STAGE] = s_q.stage;
        end else if (bus.reg_addr == DEV_EP0RX_CF) begin
            rd[RXC_ENABLE] = s_q.rx_en;
            rd[RXC_FIFOEN] = s_q.rx_fifo_en;
        end else if (bus.reg_addr == DEV_EP1_CF) begin
            rd[0] = s_q.ep1_en;
        end else if (bus.reg_addr == DEV_STATUS) begin
            rd[DST_CONN]   = connected;
            rd[DST_SUSP]   = s_q.susp;
            rd[DST_EP1RUN] = ep1_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        if (bus.reg_re) begin
            s_d.rdata = rd;
        end

        // Software writes first, so hardware events below win over clears.
        if (bus.reg_we) begin
            if (bus.reg_addr == DEV_INT) begin
                if (bus.reg_wdata == RST_CLEAR) begin
                    s_d.intr[IRQ_RST] = 1'b0;
                end else if (bus.reg_wdata == SUS_CLEAR) begin
                    s_d.intr[IRQ_SUS] = 1'b0;
                    s_d.susp = 1'b1;
                end else begin
                    s_d.intr = s_q.intr & ~bus.reg_wdata[IRQ_W-1:0];
                end
            end else if (bus.reg_addr == DEV_MASK) begin
                s_d.mask = bus.reg_wdata[IRQ_W-1:0];
            end else if (bus.reg_addr == DEV_TX0_CF) begin
                s_d.tx_en = bus.reg_wdata[TXC_ENABLE];
                if (bus.reg_wdata[TXC_CLEAR]) begin
                    s_d.under = 1'b0;
                    s_d.over  = 1'b0;
                end
            end else if (bus.reg_addr == DEV_TX0_ST) begin
                s_d.ack   = s_q.ack & bus.reg_wdata[TXS_ACK];
                s_d.stage = s_q.stage & bus.reg_wdata[TXS_STAGE];
            end else if (bus.reg_addr == DEV_EP0RX_CF) begin
                s_d.rx_en = bus.reg_wdata[RXC_ENABLE];
                if (bus.reg_wdata[RXC_FIFOEN]) begin
                    s_d.rx_fifo_en = 1'b1;
                end
            end else if (bus.reg_addr == DEV_EP1_CF) begin
                s_d.ep1_en = bus.reg_wdata[0];
            end
        end

        // Events count only while attached; a host reset always acts.
        // Acknowledge, under-run and over-run share the transmit interrupt bit.
        if (ep0_tx_ack && connected) begin
            s_d.ack   = 1'b1;
            s_d.stage = ep0_tx_stage;
        end

        if (ep0_tx_under && connected) begin
            s_d.under = 1'b1;
        end

        if (ep0_tx_over && connected) begin
            s_d.over = 1'b1;
        end

        s_d.intr[IRQ_TX0] = s_d.ack | s_d.under | s_d.over;

        // A received packet disarms the FIFO until software enables it again.
        if (ep0_rx_done && connected && s_q.rx_fifo_en) begin
            s_d.rx_fifo_en      = 1'b0;
            s_d.intr[IRQ_EP0RX] = 1'b1;
        end

        if (ep1_tx_ack && ep1_active) begin
            s_d.intr[IRQ_EP1TX] = 1'b1;
        end

        if (usb_suspend && connected) begin
            s_d.intr[IRQ_SUS] = 1'b1;
        end

        // A new setup or host reset wipes pending bits before flagging itself.
        if (usb_setup && connected) begin
            s_d.intr = '0;
            s_d.ack  = 1'b0;
            s_d.intr[IRQ_EP0RX] = 1'b1;
        end

        if (usb_reset) begin
            s_d.intr       = '0;
            s_d.ep1_en     = 1'b0;
            s_d.rx_fifo_en = 1'b0;
            s_d.ack        = 1'b0;
            s_d.under      = 1'b0;
            s_d.over       = 1'b0;
            s_d.stage      = 1'b0;
            s_d.susp       = 1'b0;
            s_d.intr[IRQ_RST] = 1'b1;
        end

        if (!aresetn) begin
            s_d      = '0;
            s_d.intr = INT_RESET[IRQ_W-1:0];
            s_d.mask = MASK_RESET[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign connected     = s_q.tx_en & s_q.rx_en;
    assign ep1_active    = connected & s_q.ep1_en;
    assign rx_armed      = s_q.rx_fifo_en;
    assign suspended     = s_q.susp;
    assign bus.reg_rdata = s_q.rdata;
    assign pend          = s_q.intr & s_q.mask;
    assign bus.irq_n     = ~|pend;

endmodule

// File: verification/efn_properties.sv
`timescale 1ns/10ps
module efn_properties
    import efn_pkg::*;
(
    input wire logic       aclk,       // Clock.
    input wire logic       aresetn,    // Reset, active low.
    input wire logic       irq_n,      // Device request, active low.
    input wire logic       reg_we,     // Register write strobe.
    input wire logic       reg_re,     // Register read strobe.
    input wire logic [3:0] reg_addr,   // Register index.
    input wire logic [7:0] reg_wdata,  // Write data.
    input wire logic [7:0] reg_rdata   // Read data.
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Shadow of what the controller last wrote, kept to judge the device's answers.
    typedef struct packed {
        logic [4:0] mask;
        logic       tx;
        logic       rx;
        logic       ep1;
        logic       func_reset_event;
        logic       susp;
    } shadow_t;
    shadow_t s_q;
    shadow_t s_d;

    always_comb begin
        s_d = s_q;
        if (reg_we) begin
            case (reg_addr)
                DEV_MASK: s_d.mask = reg_wdata[4:0];
                DEV_TX0_CF: s_d.tx = reg_wdata[TXC_ENABLE];
                DEV_EP0RX_CF: s_d.rx = reg_wdata[RXC_ENABLE];
                DEV_EP1_CF: s_d.ep1 = reg_wdata[0];
                DEV_INT: begin
                    s_d.func_reset_event = (reg_wdata == RST_CLEAR);
                    s_d.susp = s_q.susp | (reg_wdata == SUS_CLEAR);
                end
                default: s_d.susp = s_q.susp;
            endcase
        end
        if (reg_re && reg_addr == DEV_INT) begin
            s_d.func_reset_event = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_irq_idle_reset: assert property (disable iff (1'b0) !aresetn |=> irq_n)
        else $error("request line low after reset");
    a_conn_both_en: assert property (reg_re && reg_addr == DEV_STATUS && !(s_q.tx && s_q.rx)
        |=> !reg_rdata[DST_CONN]) else $error("connected without both enables");
    a_mask_blocks_irq: assert property (!irq_n |-> s_q.mask != 5'h00)
        else $error("request low with all masks clear");
    a_int_five_src: assert property (reg_re && reg_addr == DEV_INT
        |=> reg_rdata[7:5] == 3'h0) else $error("unused interrupt bits set");
    a_ep1_gate: assert property (reg_re && reg_addr == DEV_STATUS && !s_q.ep1
        |=> !reg_rdata[DST_EP1RUN]) else $error("endpoint 1 runs while disabled");
    a_irq_has_source: assert property (reg_re && reg_addr == DEV_INT && !irq_n
        |=> (reg_rdata[4:0] & s_q.mask) != 5'h00) else $error("request low without source");
    a_func_reset_event_cleared: assert property (reg_re && reg_addr == DEV_INT && s_q.func_reset_event
        |=> !reg_rdata[IRQ_RST]) else $error("reset interrupt not cleared");
    a_susp_entered: assert property (reg_re && reg_addr == DEV_STATUS && s_q.susp
        |=> reg_rdata[DST_SUSP]) else $error("suspend not entered");

    c_irq_low: cover property (!irq_n);
    c_susp_write: cover property (reg_we && reg_addr == DEV_INT && reg_wdata == SUS_CLEAR);
    c_status_read: cover property (reg_re && reg_addr == DEV_STATUS);
endmodule

// File: verification/testbench.sv
`timescale 1ns/10ps
module testbench
    import efn_pkg::*;
;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [5:0]  awaddr  = 6'h00;
    logic [5:0]  araddr  = 6'h00;
    logic [31:0] wdata   = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic [7:0]  ev      = 8'h00;
    logic        stg     = 1'b0;
    logic [31:0] seed    = 32'h000116a1;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic        connected, rx_armed, ep1_active, suspended;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [4:0]  m;
    logic [1:0]  wq[$];
    logic [33:0] rq[$];
    logic [31:0] mq[$];
    logic [33:0] rx_note;
    int          error_cnt = 0;
    int          checked   = 0;
    int          cyc       = 0;
    int          evb[4]    = '{3, 6, 7, 0};

    efn_if bus ();
    efn_device i_efn_device (.aclk(aclk), .aresetn(aresetn), .bus(bus), .usb_reset(ev[0]),
        .usb_setup(ev[1]), .usb_suspend(ev[2]), .ep0_tx_ack(ev[3]), .ep0_tx_stage(stg),
        .ep0_tx_under(ev[4]), .ep0_tx_over(ev[5]), .ep0_rx_done(ev[6]), .ep1_tx_ack(ev[7]),
        .connected(connected), .rx_armed(rx_armed), .ep1_active(ep1_active),
        .suspended(suspended));
    efn_ctrl i_efn_ctrl (.aclk(aclk), .aresetn(aresetn), .bus(bus), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .irq(irq));
    efn_properties i_efn_properties (.aclk(aclk), .aresetn(aresetn), .irq_n(bus.irq_n),
        .reg_we(bus.reg_we), .reg_re(bus.reg_re), .reg_addr(bus.reg_addr),
        .reg_wdata(bus.reg_wdata), .reg_rdata(bus.reg_rdata));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] k);
        checked++;
        if ((got & k) !== (exp & k)) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Ready and valid are sampled at the falling edge, which holds the value seen at the next rise.
    task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta;
        logic tw;
        logic tb;
        tb = 1'b0;
        @(posedge aclk);
        wq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
    endtask

    task automatic axi_rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] k,
                          input logic [1:0] r);
        logic ta;
        logic tb;
        tb = 1'b0;
        @(posedge aclk);
        rq.push_back({r, e});
        mq.push_back(k);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tb = rvalid;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tb) rready <= 1'b0;
        end
    endtask

    task automatic dev_wr(input logic [3:0] idx, input logic [7:0] v);
        axi_wr(C_WDATA, {24'h0, v}, RESP_OKAY);
        axi_wr(C_CMD, {28'h0, idx}, RESP_OKAY);
        repeat (4) @(posedge aclk);
    endtask

    task automatic dev_rd(input logic [3:0] idx, input logic [7:0] e);
        axi_wr(C_CMD, {23'h0, 1'b1, 4'h0, idx}, RESP_OKAY);
        repeat (5) @(posedge aclk);
        axi_rd(C_RDATA, {24'h0, e}, 32'hffff_ffff, RESP_OKAY);
    endtask

    task automatic pulse(input int i);
        @(posedge aclk);
        ev <= 8'h01 << i;
        @(posedge aclk);
        ev <= 8'h00;
        repeat (2) @(posedge aclk);
    endtask

    always #4 aclk = ~aclk;

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end

    always @(negedge aclk) begin
        if (bvalid && bready) cmp_resp(bresp, wq.pop_front());
        if (rvalid && rready) begin
            rx_note = rq.pop_front();
            cmp_resp(rresp, rx_note[33:32]);
            cmp_data(rdata, rx_note[31:0], mq.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        cmp_bit(bus.irq_n, 1'b1);
        dev_rd(DEV_INT, INT_RESET);
        dev_rd(DEV_STATUS, 8'h00);
        axi_rd(6'h18, 32'h0, 32'h0, RESP_SLVERR);
        axi_wr(6'h1c, 32'h0, RESP_SLVERR);
        dev_wr(DEV_TX0_CF, 8'h01);
        @(negedge aclk);
        cmp_bit(connected, 1'b0);
        dev_wr(DEV_EP0RX_CF, 8'h03);
        @(negedge aclk);
        cmp_bit(connected, 1'b1);
        cmp_bit(rx_armed, 1'b1);
        cmp_bit(ep1_active, 1'b0);
        dev_wr(DEV_EP1_CF, 8'h01);
        @(negedge aclk);
        cmp_bit(ep1_active, 1'b1);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            m = seed[4:0];
            stg <= seed[7];
            dev_wr(DEV_MASK, {3'h0, m});
            pulse(evb[i]);
            repeat (5) @(posedge aclk);
            @(negedge aclk);
            cmp_bit(bus.irq_n, !m[i]);
            dev_rd(DEV_INT, 8'h01 << i);
            if (i == 0) begin
                dev_rd(DEV_TX0_ST, {4'h0, stg, 3'h1});
                dev_wr(DEV_TX0_ST, 8'h00);
            end else begin
                dev_wr(DEV_INT, 8'h01 << i);
            end
            dev_rd(DEV_INT, 8'h00);
        end
        @(negedge aclk);
        cmp_bit(connected, 1'b1);
        cmp_bit(rx_armed, 1'b0);
        cmp_bit(ep1_active, 1'b0);
        dev_rd(DEV_MASK, {3'h0, m});
        for (int j = 1; j < 3; j++) begin
            pulse(3 + j);
            dev_rd(DEV_TX0_ST, 8'h01 << j);
            dev_rd(DEV_INT, 8'h01);
            dev_wr(DEV_TX0_CF, 8'h03);
            dev_rd(DEV_TX0_ST, 8'h00);
            dev_rd(DEV_INT, 8'h00);
        end
        pulse(7);
        dev_rd(DEV_INT, 8'h00);
        dev_wr(DEV_EP1_CF, 8'h01);
        pulse(7);
        pulse(1);
        dev_rd(DEV_INT, 8'h02);
        dev_wr(DEV_INT, 8'h02);
        axi_wr(C_IMASK, 32'h2, RESP_OKAY);
        dev_wr(DEV_MASK, 8'h1f);
        dev_wr(DEV_EP0RX_CF, 8'h03);
        @(negedge aclk);
        cmp_bit(rx_armed, 1'b1);
        pulse(6);
        dev_wr(DEV_INT, 8'h02);
        @(negedge aclk);
        cmp_bit(irq, 1'b1);
        axi_rd(C_STAT, 32'h2, 32'h2, RESP_OKAY);
        @(negedge aclk);
        cmp_bit(irq, 1'b0);
        axi_wr(C_IMASK, 32'h4, RESP_OKAY);
        axi_wr(C_TIMER, 32'ha, RESP_OKAY);
        repeat (14) @(posedge aclk);
        @(negedge aclk);
        cmp_bit(irq, 1'b1);
        pulse(2);
        dev_rd(DEV_INT, 8'h10);
        dev_wr(DEV_INT, SUS_CLEAR);
        @(negedge aclk);
        cmp_bit(suspended, 1'b1);
        cmp_bit(bus.irq_n, 1'b1);
        dev_rd(DEV_STATUS, 8'h07);
        end_sim();
    end
endmodule
